// file: src/cepm_pkg.sv
// Package for the core energy and power monitor: constants, functions and request types.
//
// Summary of operation
// - Sample core power 10000 times per second.
// - Energy total is 64 bits, two reads.
// - Lower read latches total, returns low word.
// - Upper read returns latched upper word.
// - Lone upper read leaves holding registers alone.
// - Writing zero to lower half clears total.
// - Reset clears the energy accumulator.
// - Energy device 0 lower, 1 upper.
// - Voltage device 0 sets and reads supply.
// - Current device 0 reports total current.
// - Power device 0 reports total power.
// - Voltage, current, temperature readable by controller.
package cepm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int SAMPLE_RATE_HZ = 10000;
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_RATE_HZ;
  localparam int SAMPLE_INTERVAL_US = 100;
  localparam logic [10:0] SAMPLE_LAST = 11'(SAMPLE_CYCLES - 1);

  // ----------------------------------------------------------------
  // Device functions and numbers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CEPM_FN_VOLT,
    CEPM_FN_CURR,
    CEPM_FN_POWER,
    CEPM_FN_TEMP,
    CEPM_FN_ENERGY
  } cepm_fn_e;

  localparam logic [11:0] DEV_VOLT = 12'h000;
  localparam logic [11:0] DEV_CURR = 12'h000;
  localparam logic [11:0] DEV_POWER = 12'h000;
  localparam logic [11:0] DEV_TEMP = 12'h000;
  localparam logic [11:0] DEV_ENERGY_LO = 12'h000;
  localparam logic [11:0] DEV_ENERGY_HI = 12'h001;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  // Core supply setting in millivolts; 900 mV is the nominal default.
  localparam logic [31:0] VOLT_RESET_MV = 32'h0000_0384;
  localparam logic [63:0] ENERGY_RESET = 64'h0000_0000_0000_0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    cepm_fn_e fn;
    logic [11:0] dev;
    logic [31:0] wdata;
  } cepm_req_s;

  typedef struct packed {
    logic valid;
    logic err;
    logic [31:0] rdata;
  } cepm_rsp_s;

  // Measurements: voltage in mV, current in mA, power in mW, temperature in raw units.
  typedef struct packed {
    logic [31:0] volt_mv;
    logic [31:0] curr_ma;
    logic [31:0] power_mw;
    logic [31:0] temp;
  } cepm_meas_s;

endpackage

// file: src/cepm_monitor.sv
// Core energy and power monitor answering the configuration controller's device requests.
`timescale 1ns/100ps
module cepm_monitor
  import cepm_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire cepm_req_s req_i,
  input wire cepm_meas_s meas_i,
  output cepm_rsp_s rsp_o,
  output logic [31:0] volt_set_mv_o
);

  // ----------------------------------------------------------------
  // Measurement input synchronisers
  // ----------------------------------------------------------------
  // The converters sit off-chip, so their words pass two flops first.
  // A word caught mid-change can be wrong for one sample; that is
  // accepted in exchange for avoiding a handshake with the converter.
  cepm_meas_s meas_s1;
  cepm_meas_s meas_s2;
  cepm_meas_s next_meas_s1;
  cepm_meas_s next_meas_s2;

  always_comb begin
    next_meas_s1 = meas_i;
    next_meas_s2 = meas_s1;
  end

  always_ff @(posedge clock_i) begin
    meas_s1 <= next_meas_s1;
    meas_s2 <= next_meas_s2;
  end

  // ----------------------------------------------------------------
  // Sample tick and energy accumulator
  // ----------------------------------------------------------------
  logic [10:0] tick_cnt;
  logic [10:0] next_tick_cnt;
  logic tick;
  logic [63:0] energy;
  logic [63:0] next_energy;
  logic [63:0] sample_uj;
  logic energy_lo_sel;
  logic energy_hi_sel;
  logic clear_req;

  assign tick = (tick_cnt == SAMPLE_LAST);
  assign energy_lo_sel = req_i.valid && (req_i.fn == CEPM_FN_ENERGY) && (req_i.dev == DEV_ENERGY_LO);
  assign energy_hi_sel = req_i.valid && (req_i.fn == CEPM_FN_ENERGY) && (req_i.dev == DEV_ENERGY_HI);
  assign clear_req = energy_lo_sel && req_i.write && (req_i.wdata == WORD_ZERO);

  // Power in mW times 100 us gives nJ; dividing by 1000 yields uJ.
  // The truncated remainder is lost per sample, a known small under-read.
  assign sample_uj = 64'(meas_s2.power_mw) * 64'(SAMPLE_INTERVAL_US) / 64'h0000_0000_0000_03E8;

  always_comb begin
    next_tick_cnt = tick ? 11'h000 : 11'(tick_cnt + 11'h001);
    next_energy = energy;
    if (clear_req) begin
      next_energy = ENERGY_RESET;
    end else if (tick) begin
      next_energy = energy + sample_uj;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      tick_cnt <= 11'h000;
      energy <= ENERGY_RESET;
    end else begin
      tick_cnt <= next_tick_cnt;
      energy <= next_energy;
    end
  end

  // ----------------------------------------------------------------
  // Request decode, holding registers and answers
  // ----------------------------------------------------------------
  logic [31:0] hold_lo;
  logic [31:0] hold_hi;
  logic [31:0] volt_set;
  cepm_rsp_s rsp;
  logic [31:0] next_hold_lo;
  logic [31:0] next_hold_hi;
  logic [31:0] next_volt_set;
  cepm_rsp_s next_rsp;

  always_comb begin
    next_hold_lo = hold_lo;
    next_hold_hi = hold_hi;
    next_volt_set = volt_set;
    next_rsp.valid = req_i.valid;
    next_rsp.err = 1'b0;
    next_rsp.rdata = WORD_ZERO;
    if (req_i.valid) begin
      unique case (req_i.fn)
        CEPM_FN_VOLT: begin
          if (req_i.dev != DEV_VOLT) begin
            next_rsp.err = 1'b1;
          end else if (req_i.write) begin
            next_volt_set = req_i.wdata;
          end else begin
            next_rsp.rdata = meas_s2.volt_mv;
          end
        end
        CEPM_FN_CURR: begin
          next_rsp.err = req_i.write || (req_i.dev != DEV_CURR);
          next_rsp.rdata = next_rsp.err ? WORD_ZERO : meas_s2.curr_ma;
        end
        CEPM_FN_POWER: begin
          next_rsp.err = req_i.write || (req_i.dev != DEV_POWER);
          next_rsp.rdata = next_rsp.err ? WORD_ZERO : meas_s2.power_mw;
        end
        CEPM_FN_TEMP: begin
          next_rsp.err = req_i.write || (req_i.dev != DEV_TEMP);
          next_rsp.rdata = next_rsp.err ? WORD_ZERO : meas_s2.temp;
        end
        CEPM_FN_ENERGY: begin
          if (energy_lo_sel && !req_i.write) begin
            next_hold_lo = energy[31:0];
            next_hold_hi = energy[63:32];
            next_rsp.rdata = energy[31:0];
          end else if (energy_hi_sel && !req_i.write) begin
            // Holding registers stay put; a lone upper read gets stale data.
            next_rsp.rdata = hold_hi;
          end else if (!energy_lo_sel || (req_i.wdata != WORD_ZERO)) begin
            // Only a zero write to the lower half is meaningful.
            next_rsp.err = 1'b1;
          end
        end
        default: begin
          next_rsp.err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      hold_lo <= WORD_ZERO;
      hold_hi <= WORD_ZERO;
      volt_set <= VOLT_RESET_MV;
      rsp <= '0;
    end else begin
      hold_lo <= next_hold_lo;
      hold_hi <= next_hold_hi;
      volt_set <= next_volt_set;
      rsp <= next_rsp;
    end
  end

  assign rsp_o = rsp;
  assign volt_set_mv_o = volt_set;

  // ----------------------------------------------------------------
  // Assertion helper: cycles since the last sample tick
  // ----------------------------------------------------------------
  // A gap of 2000 cycles is too long to unroll in a property, so a
  // separate counter measures it. It saturates rather than wrapping so
  // that a lost tick cannot line up with the expected gap by chance.
  logic [10:0] gap_cnt;
  logic [10:0] next_gap_cnt;

  always_comb begin
    next_gap_cnt = gap_cnt;
    if (tick) begin
      next_gap_cnt = 11'h000;
    end else if (gap_cnt != 11'h7FF) begin
      next_gap_cnt = 11'(gap_cnt + 11'h001);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      gap_cnt <= 11'h000;
    end else begin
      gap_cnt <= next_gap_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  AST_TICK_PERIOD: assert property (tick |=> !tick [*8])
    else $error("Sample tick repeated too soon.");
  AST_TICK_SPACING: assert property (tick == (gap_cnt == SAMPLE_LAST))
    else $error("Sample tick spacing wrong.");
  AST_LO_LATCH: assert property (energy_lo_sel && !req_i.write && !clear_req |=>
      hold_lo == $past(energy[31:0]) && hold_hi == $past(energy[63:32]))
    else $error("Lower read did not latch total.");
  AST_LO_DATA: assert property (energy_lo_sel && !req_i.write |=>
      rsp_o.valid && rsp_o.rdata == $past(energy[31:0]))
    else $error("Lower read answer wrong.");
  AST_HI_DATA: assert property (energy_hi_sel && !req_i.write |=> rsp_o.rdata == $past(hold_hi))
    else $error("Upper read did not return held word.");
  AST_HI_STALE: assert property (energy_hi_sel |=> $stable(hold_hi) && $stable(hold_lo))
    else $error("Upper read changed holding registers.");
  AST_CLEAR: assert property (clear_req |=> energy == ENERGY_RESET)
    else $error("Zero write did not clear energy.");
  AST_ACCUM: assert property (tick && !clear_req |=> energy == $past(energy) + $past(sample_uj))
    else $error("Sample not added to total.");
  AST_HOLD: assert property (!tick && !clear_req |=> $stable(energy))
    else $error("Energy changed between samples.");
  AST_VOLT_WR: assert property (req_i.valid && req_i.write && req_i.fn == CEPM_FN_VOLT
      && req_i.dev == DEV_VOLT |=> volt_set_mv_o == $past(req_i.wdata))
    else $error("Voltage setting not taken.");
  AST_RESP: assert property (req_i.valid |=> rsp_o.valid)
    else $error("Request got no answer.");
  AST_RESP_IDLE: assert property (!req_i.valid |=> !rsp_o.valid)
    else $error("Answer given without a request.");
  AST_BAD_DEV: assert property (req_i.valid && req_i.fn == CEPM_FN_VOLT && req_i.dev != DEV_VOLT |=>
      rsp_o.err && $stable(volt_set_mv_o))
    else $error("Voltage request to a missing device not refused.");
  AST_NZ_WRITE: assert property (energy_lo_sel && req_i.write && req_i.wdata != WORD_ZERO && !tick |=>
      rsp_o.err && $stable(energy))
    else $error("Nonzero write disturbed the total.");

  COV_LO_HI: cover property (energy_lo_sel && !req_i.write ##[1:20] energy_hi_sel && !req_i.write);
  COV_HI_FIRST: cover property (energy_hi_sel && !req_i.write);
  COV_CLEAR: cover property (clear_req);
  COV_TICK_ADD: cover property (tick && sample_uj != 64'h0000_0000_0000_0000);
  COV_BAD_DEV: cover property (req_i.valid && req_i.fn == CEPM_FN_VOLT && req_i.dev != DEV_VOLT);

endmodule

// file: tb/cepm_ctrl_model.sv
// Requester model standing in for the motherboard configuration controller.
`timescale 1ns/100ps
module cepm_ctrl_model
  import cepm_pkg::*;
(
  input wire logic clock_i,
  output cepm_req_s req_o,
  input wire cepm_rsp_s rsp_i
);
  initial begin
    req_o = '0;
  end

  // One request per call, held across the taking edge. The answer is registered on that edge,
  // so it is picked up just after it. Write, device and data fields are inverted on release so stale values never
  // look like a live request. Energy callers fetch the lower word first, except the lone upper read in t_energy.
  task automatic xfer(input logic wr, input cepm_fn_e fn, input logic [11:0] dev,
                      input logic [31:0] wd, output cepm_rsp_s rsp);
    @(posedge clock_i);
    #1 req_o = {1'b1, wr, fn, dev, wd};
    @(posedge clock_i);
    #1 req_o = {1'b0, ~wr, fn, ~dev, ~wd};
    rsp = rsp_i;
  endtask
endmodule

// file: tb/core_energy_power_monitor_tb.sv
// Self-checking testbench for the core energy and power monitor.
`timescale 1ns/100ps
module core_energy_power_monitor_tb;
  import cepm_pkg::*;
  logic clock_i;
  logic nrst_i;
  cepm_req_s req;
  cepm_meas_s meas;
  cepm_rsp_s rsp;
  logic [31:0] volt_set;
  int n_fail;
  int checks_done;
  localparam logic [31:0] PWR = 32'hFFFF_FFF0;
  // One sample adds power in mW times 100 us, giving microjoules.
  localparam logic [63:0] INC = (64'(PWR) * 100) / 1000;

  cepm_monitor cepm_monitor_i(.clock_i(clock_i), .nrst_i(nrst_i), .req_i(req), .meas_i(meas),
                              .rsp_o(rsp), .volt_set_mv_o(volt_set));
  cepm_ctrl_model cepm_ctrl_model_i(.clock_i(clock_i), .req_o(req), .rsp_i(rsp));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic op(input logic wr, input cepm_fn_e fn, input logic [11:0] dev,
                    input logic [31:0] wd, input logic e_err, output logic [31:0] rd);
    cepm_rsp_s r;
    cepm_ctrl_model_i.xfer(wr, fn, dev, wd, r);
    check({r.valid, r.err}, {1'b1, e_err});
    rd = r.rdata;
  endtask

  task automatic read64(output logic [63:0] v);
    op(1'b0, CEPM_FN_ENERGY, DEV_ENERGY_LO, WORD_ZERO, 1'b0, v[31:0]);
    op(1'b0, CEPM_FN_ENERGY, DEV_ENERGY_HI, WORD_ZERO, 1'b0, v[63:32]);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [63:0] v;
    check(64'(volt_set), 64'(VOLT_RESET_MV));
    read64(v);
    check(v, ENERGY_RESET);
  endtask

  // Two 64-bit reads exactly eleven sample periods apart, so the total spills into the upper word,
  // then a clear. The lone upper read after the clear must still show the held word, which is
  // nonzero, even though the live total is zero.
  task automatic t_energy();
    logic [63:0] a;
    logic [63:0] b;
    logic [63:0] c;
    logic [31:0] h;
    read64(a);
    check(a, ENERGY_RESET);
    repeat (11 * SAMPLE_CYCLES - 4) @(posedge clock_i);
    read64(b);
    check(b - a, 11 * INC);
    op(1'b1, CEPM_FN_ENERGY, DEV_ENERGY_LO, WORD_ZERO, 1'b0, h);
    op(1'b0, CEPM_FN_ENERGY, DEV_ENERGY_HI, WORD_ZERO, 1'b0, h);
    check(64'(h), (11 * INC) >> 32);
    read64(c);
    check(c, ENERGY_RESET);
  endtask

  task automatic t_meas();
    logic [31:0] d;
    op(1'b1, CEPM_FN_VOLT, DEV_VOLT, 32'h0000_03E8, 1'b0, d);
    check(64'(volt_set), 64'h0000_0000_0000_03E8);
    op(1'b1, CEPM_FN_VOLT, 12'h001, 32'h0000_0001, 1'b1, d);
    check(64'(volt_set), 64'h0000_0000_0000_03E8);
    op(1'b0, CEPM_FN_VOLT, DEV_VOLT, WORD_ZERO, 1'b0, d);
    check(64'(d), 64'(meas.volt_mv));
    op(1'b0, CEPM_FN_CURR, DEV_CURR, WORD_ZERO, 1'b0, d);
    check(64'(d), 64'(meas.curr_ma));
    op(1'b0, CEPM_FN_POWER, DEV_POWER, WORD_ZERO, 1'b0, d);
    check(64'(d), 64'(meas.power_mw));
    op(1'b0, CEPM_FN_TEMP, DEV_TEMP, WORD_ZERO, 1'b0, d);
    check(64'(d), 64'(meas.temp));
    op(1'b1, CEPM_FN_ENERGY, DEV_ENERGY_LO, 32'h0000_0001, 1'b1, d);
    op(1'b1, CEPM_FN_ENERGY, DEV_ENERGY_HI, WORD_ZERO, 1'b1, d);
  endtask

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // The run needs about 22100 cycles; the margin covers a stuck handshake.
  initial begin
    #(30_000 * 50);
    n_fail++;
    stop_test();
  end

  initial begin
    n_fail = 0;
    checks_done = 0;
    nrst_i = 1'b0;
    meas = {32'h0000_0370, 32'h0000_1234, PWR, 32'h0000_0041};
    repeat (8) @(posedge clock_i);
    #1 nrst_i = 1'b1;
    t_reset();
    t_energy();
    t_meas();
    stop_test();
  end
endmodule
